// >>> inc/car_pkg.sv
// Constants and types shared by the card address register block.
// Assumes one reference clock domain; the card clock is a sampled pin.
package car_pkg;

    // ==========================================================
    // Command frame layout on the command line
    localparam int          FRAME_BITS   = 48;
    localparam int          CRC_BITS     = 7;
    localparam int          CRC_SPAN     = 40;
    localparam int          IDX_LSB      = 40;
    localparam int          ARG_LSB      = 8;
    localparam int          ADDR_LSB     = 16;
    localparam logic [6:0]  CRC_POLY     = 7'h09;

    // ==========================================================
    // Command indices
    localparam logic [5:0]  CMD_SW_RESET      = 6'h00;
    localparam logic [5:0]  CMD_SEND_OPCOND   = 6'h01;
    localparam logic [5:0]  CMD_ALL_SEND_ID   = 6'h02;
    localparam logic [5:0]  CMD_SET_ADDR      = 6'h03;
    localparam logic [5:0]  CMD_CARD_SELECT   = 6'h07;
    localparam logic [5:0]  CMD_SEND_SPECIFIC = 6'h09;
    localparam logic [5:0]  CMD_SEND_IDENTITY = 6'h0a;
    localparam logic [5:0]  CMD_SEND_STATUS   = 6'h0d;
    localparam logic [5:0]  CMD_GO_INACTIVE   = 6'h0f;

    // ==========================================================
    // Relative address register
    localparam logic [15:0] RCA_RESET    = 16'h0001;
    localparam logic [15:0] RCA_ALL_STBY = 16'h0000;

    // ==========================================================
    // Native status word fields
    localparam int          ST_ILLEGAL   = 22;
    localparam int          ST_STATE_LSB = 9;
    localparam int          ST_READY     = 8;
    localparam logic [3:0]  CODE_IDLE    = 4'h0;
    localparam logic [3:0]  CODE_READY   = 4'h1;
    localparam logic [3:0]  CODE_IDENT   = 4'h2;
    localparam logic [3:0]  CODE_STBY    = 4'h3;
    localparam logic [3:0]  CODE_TRAN    = 4'h4;

    // Short status format used in the serial-peripheral mode
    localparam int          SPI_ST_IDLE    = 0;
    localparam int          SPI_ST_ILLEGAL = 2;

    // ==========================================================
    // Register blocks and their size in bytes
    localparam int          ID_BYTES     = 16;
    localparam logic        ID_SEL_CID   = 1'b0;
    localparam logic        ID_SEL_CSD   = 1'b1;

    typedef enum logic [2:0] {
        CAR_REG_CID,
        CAR_REG_CSD,
        CAR_REG_RCA,
        CAR_REG_DSR,
        CAR_REG_OCR
    } car_reg_sel_t;

    typedef enum logic [2:0] {
        CAR_INACTIVE,
        CAR_IDLE,
        CAR_READY,
        CAR_IDENT,
        CAR_STBY,
        CAR_TRAN
    } car_state_t;

    typedef struct packed {
        logic [5:0]  index;
        logic [31:0] arg;
    } car_cmd_t;

    typedef struct packed {
        car_reg_sel_t sel;
        logic [3:0]   byte_idx;
    } car_rd_req_t;

endpackage

// >>> rtl/car_id_mem.sv
// Byte memory holding the identity block and the card-specific block.
// Assumes a single clock; read data is registered, one cycle latency.
`timescale 1ns/1ps
module car_id_mem
    import car_pkg::*;
#(
    parameter int DEPTH = 2 * ID_BYTES,
    parameter int AW    = $clog2(DEPTH)
)
(
    // Clock
    input  wire logic          clk_i,
    // Write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    // Read port
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);

    // Elaboration-time refusal of a depth the address cannot reach
    if (DEPTH < 2 || DEPTH > (1 << AW))
    begin : g_bad_depth
        $error("car_id_mem: DEPTH does not fit AW");
    end

    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
            mem[waddr_i] <= wdata_i;
        rdata_o <= mem[raddr_i];
    end

endmodule

// >>> rtl/car_regs.sv
// Card-side command decode and register access for the relative address.
// Assumes card clock and command line arrive as pins from the host; the
// serial-peripheral mode level and register reads come from card logic.
`timescale 1ns/1ps
module car_regs
    import car_pkg::*;
#(
    parameter logic [31:0] OCR_VALUE = 32'h00ff8000,
    parameter logic [15:0] DSR_VALUE = 16'h0404
)
(
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    // Card bus pins
    input  wire logic         card_clk_i,
    input  wire logic         cmd_i,
    // Mode
    input  wire logic         spi_mode_i,
    // Identity memory loading
    input  wire logic         id_wr_i,
    input  wire logic         id_wr_blk_i,
    input  wire logic [3:0]   id_wr_idx_i,
    input  wire logic [7:0]   id_wr_data_i,
    // Register read port
    input  wire logic         rd_i,
    input  wire car_rd_req_t  rd_req_i,
    output logic              rd_done_o,
    output logic              rd_refused_o,
    output logic      [7:0]   rd_data_o,
    // Decoded commands
    output logic              cmd_valid_o,
    output car_cmd_t          cmd_o,
    output logic              cmd_for_me_o,
    // Card state
    output logic      [15:0]  rca_o,
    output car_state_t        state_o,
    output logic      [31:0]  status_o
);

    // ==========================================================
    // Pin synchronisers and card clock edge
    logic [2:0] clk_sync;
    logic [1:0] cmd_sync;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            clk_sync <= 3'h0;
            cmd_sync <= 2'h3;
        end
        else
        begin
            clk_sync <= {clk_sync[1:0], card_clk_i};
            cmd_sync <= {cmd_sync[0], cmd_i};
        end
    end

    wire clk_rise = clk_sync[1] & ~clk_sync[2];
    wire cmd_bit  = cmd_sync[1];

    // ==========================================================
    // Frame receiver
    logic [FRAME_BITS-1:0] shift;
    logic [5:0]            bit_cnt;
    logic                  in_frame;

    localparam logic [5:0] LAST_BIT = 6'(FRAME_BITS - 1);

    wire                  frame_end = clk_rise & in_frame
                                      & (bit_cnt == LAST_BIT);
    wire [FRAME_BITS-1:0] frame_w   = {shift[FRAME_BITS-2:0], cmd_bit};

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            shift    <= '0;
            bit_cnt  <= 6'h00;
            in_frame <= 1'b0;
        end
        else if (clk_rise)
        begin
            shift <= frame_w;
            if (!in_frame)
            begin
                in_frame <= ~cmd_bit;
                bit_cnt  <= 6'h01;
            end
            else if (bit_cnt == LAST_BIT)
            begin
                in_frame <= 1'b0;
                bit_cnt  <= 6'h00;
            end
            else
                bit_cnt <= bit_cnt + 6'h01;
        end
    end

    function automatic logic [6:0] crc7(input logic [CRC_SPAN-1:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = CRC_SPAN - 1; i >= 0; i--)
        begin
            fb = d[i] ^ c[6];
            c  = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
        end
        return c;
    endfunction

    wire [5:0]  rx_idx  = frame_w[IDX_LSB +: 6];
    wire [31:0] rx_arg  = frame_w[ARG_LSB +: 32];
    wire [15:0] rx_addr = rx_arg[ADDR_LSB +: 16];
    wire [6:0]  rx_crc  = frame_w[1 +: CRC_BITS];

    // Bad framing or checksum drops the command silently
    wire frame_good = frame_end & ~frame_w[FRAME_BITS-1]
                      & frame_w[FRAME_BITS-2] & frame_w[0]
                      & (rx_crc == crc7(frame_w[FRAME_BITS-1 -: CRC_SPAN]));

    // ==========================================================
    // Command decode and card state
    car_state_t  state;
    car_state_t  next_state;
    logic [15:0] relative_card_address;
    logic [15:0] next_rca;
    logic        illegal;
    logic        next_illegal;
    logic        for_me;

    wire addr_hit = spi_mode_i | (rx_addr == relative_card_address);

    always_comb
    begin
        next_state   = state;
        next_rca     = relative_card_address;
        next_illegal = 1'b0;
        for_me       = 1'b0;
        if (rx_idx == CMD_SW_RESET)
        begin
            for_me = (state != CAR_INACTIVE);
            if (state != CAR_INACTIVE)
            begin
                next_state = CAR_IDLE;
                next_rca   = RCA_RESET;
            end
        end
        else if (state == CAR_INACTIVE)
            for_me = 1'b0;
        else if (spi_mode_i)
        begin
            for_me       = 1'b1;
            next_illegal = (rx_idx == CMD_SET_ADDR)
                           | (rx_idx == CMD_CARD_SELECT);
        end
        else
        begin
            case (rx_idx)
                CMD_SEND_OPCOND:
                begin
                    for_me       = 1'b1;
                    next_illegal = (state != CAR_IDLE);
                    if (state == CAR_IDLE)
                        next_state = CAR_READY;
                end
                CMD_ALL_SEND_ID:
                begin
                    for_me       = 1'b1;
                    next_illegal = (state != CAR_READY);
                    if (state == CAR_READY)
                        next_state = CAR_IDENT;
                end
                CMD_SET_ADDR:
                begin
                    for_me       = 1'b1;
                    next_illegal = (state != CAR_IDENT)
                                   | (rx_addr == RCA_ALL_STBY);
                    if (!next_illegal)
                    begin
                        next_rca   = rx_addr;
                        next_state = CAR_STBY;
                    end
                end
                CMD_CARD_SELECT:
                begin
                    if (state == CAR_STBY || state == CAR_TRAN)
                    begin
                        for_me     = addr_hit;
                        next_state = addr_hit ? CAR_TRAN : CAR_STBY;
                    end
                    else
                        next_illegal = 1'b1;
                end
                CMD_SEND_SPECIFIC, CMD_SEND_IDENTITY:
                begin
                    for_me       = addr_hit;
                    next_illegal = addr_hit & (state != CAR_STBY);
                end
                CMD_SEND_STATUS:
                    for_me = addr_hit;
                CMD_GO_INACTIVE:
                begin
                    for_me = addr_hit;
                    if (addr_hit)
                        next_state = CAR_INACTIVE;
                end
                default:
                    next_illegal = 1'b1;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state        <= CAR_IDLE;
            relative_card_address          <= RCA_RESET;
            illegal      <= 1'b0;
            cmd_valid_o  <= 1'b0;
            cmd_o        <= '0;
            cmd_for_me_o <= 1'b0;
        end
        else
        begin
            cmd_valid_o  <= frame_good;
            cmd_for_me_o <= frame_good & for_me;
            if (frame_good)
            begin
                state   <= next_state;
                relative_card_address     <= next_rca;
                illegal <= next_illegal;
                cmd_o   <= '{index: rx_idx, arg: rx_arg};
            end
        end
    end

    // ==========================================================
    // Status word, native or short
    function automatic logic [3:0] state_code(input car_state_t s);
        case (s)
            CAR_READY: return CODE_READY;
            CAR_IDENT: return CODE_IDENT;
            CAR_STBY:  return CODE_STBY;
            CAR_TRAN:  return CODE_TRAN;
            default:   return CODE_IDLE;
        endcase
    endfunction

    logic [31:0] native_status;
    logic [31:0] short_status;

    always_comb
    begin
        native_status                        = 32'h0000_0000;
        native_status[ST_ILLEGAL]            = illegal;
        native_status[ST_STATE_LSB +: 4]     = state_code(state);
        native_status[ST_READY]              = 1'b1;
        short_status                         = 32'h0000_0000;
        short_status[SPI_ST_IDLE]            = (state == CAR_IDLE);
        short_status[SPI_ST_ILLEGAL]         = illegal;
    end

    assign rca_o    = relative_card_address;
    assign state_o  = state;
    assign status_o = spi_mode_i ? short_status : native_status;

    // ==========================================================
    // Register read port
    wire       rd_id     = (rd_req_i.sel == CAR_REG_CID)
                           | (rd_req_i.sel == CAR_REG_CSD);
    wire       rd_deny   = spi_mode_i & ~rd_id;
    wire       rd_blk    = (rd_req_i.sel == CAR_REG_CSD) ? ID_SEL_CSD
                                                         : ID_SEL_CID;
    wire [4:0] rd_addr   = {rd_blk, rd_req_i.byte_idx};
    wire [4:0] wr_addr   = {id_wr_blk_i, id_wr_idx_i};

    logic [7:0] local_byte;
    logic [7:0] local_q;
    logic [7:0] mem_q;
    logic       use_mem;

    always_comb
    begin
        case (rd_req_i.sel)
            CAR_REG_RCA: local_byte = relative_card_address[{rd_req_i.byte_idx[0], 3'h0} +: 8];
            CAR_REG_DSR:
                local_byte = DSR_VALUE[{rd_req_i.byte_idx[0], 3'h0} +: 8];
            CAR_REG_OCR:
                local_byte = OCR_VALUE[{rd_req_i.byte_idx[1:0], 3'h0} +: 8];
            default:     local_byte = 8'h00;
        endcase
    end

    car_id_mem #(
        .DEPTH   (2 * ID_BYTES),
        .AW      (5)
    ) u_id_mem (
        .clk_i   (ref_clk_i),
        .we_i    (id_wr_i),
        .waddr_i (wr_addr),
        .wdata_i (id_wr_data_i),
        .raddr_i (rd_addr),
        .rdata_o (mem_q)
    );

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            rd_done_o    <= 1'b0;
            rd_refused_o <= 1'b0;
            local_q      <= 8'h00;
            use_mem      <= 1'b0;
        end
        else
        begin
            rd_done_o    <= rd_i & ~rd_deny;
            rd_refused_o <= rd_i & rd_deny;
            if (rd_i)
            begin
                use_mem <= rd_id;
                local_q <= rd_deny ? 8'h00 : local_byte;
            end
        end
    end

    assign rd_data_o = use_mem ? mem_q : local_q;

endmodule

// >>> verification/car_host_model.sv
// Host model: sends one command frame on request, card clock at 80 ns.
// Assumes a new frame is requested only while busy_o is low.
`timescale 1ns/1ps
module car_host_model
    import car_pkg::*;
(
    // Request
    input  wire logic        go_i,
    input  wire logic [39:0] frm_i,
    input  wire logic        bad_i,
    // Card bus
    output logic             card_clk_o,
    output logic             cmd_o,
    output logic             busy_o
);
    logic [47:0] f;
    logic [6:0]  c;
    logic        fb;

    initial
    begin
        card_clk_o = 1'b0;
        cmd_o      = 1'b1;
        busy_o     = 1'b0;
    end

    // ====================================
    // Frame sender
    // Clock stands low between frames; the line idles high
    always @(posedge go_i)
    begin
        busy_o = 1'b1;
        // Keep pin changes off the reference clock edges
        #2;
        c      = 7'h00;
        for (int i = 39; i >= 0; i--)
        begin
            fb = frm_i[i] ^ c[6];
            c  = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
        end
        f = {frm_i, c ^ {6'h00, bad_i}, 1'b1};
        for (int i = 47; i >= 0; i--)
        begin
            cmd_o = f[i];
            #40 card_clk_o = 1'b1;
            #40 card_clk_o = 1'b0;
        end
        cmd_o  = 1'b1;
        busy_o = 1'b0;
    end
endmodule

// >>> verification/car_regs_properties.sv
// Checker: timing relations at the ports of the card address block.
// Assumes one clock domain; bound to every car_regs instance.
`timescale 1ns/1ps
module car_regs_properties
    import car_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    // Inputs
    input wire logic        spi_mode_i,
    input wire logic        rd_i,
    input wire car_rd_req_t rd_req_i,
    // Outputs
    input wire logic        rd_done_o,
    input wire logic        rd_refused_o,
    input wire logic [7:0]  rd_data_o,
    input wire logic        cmd_valid_o,
    input wire car_cmd_t    cmd_o,
    input wire logic        cmd_for_me_o,
    input wire logic [15:0] rca_o,
    input wire car_state_t  state_o,
    input wire logic [31:0] status_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // ====================================
    // Decoded conditions
    wire logic [15:0] adr   = cmd_o.arg[31:16];
    wire logic        nat_v = cmd_valid_o && !spi_mode_i;
    wire logic        sel_v = nat_v && cmd_o.index == CMD_CARD_SELECT;
    wire logic        blk   = rd_req_i.sel inside {CAR_REG_CID, CAR_REG_CSD};

    // ====================================
    // Properties
    chk_reset_default: assert property ($fell(rst_i) |->
        rca_o == RCA_RESET && state_o == CAR_IDLE)
        else $error("address or state not at default after reset");
    chk_addr_load: assert property (nat_v && $past(state_o) == CAR_IDENT
        && cmd_o.index == CMD_SET_ADDR && adr != RCA_ALL_STBY
        |-> rca_o == adr && state_o == CAR_STBY)
        else $error("assigned address not taken");
    chk_addr_steady: assert property (!cmd_valid_o |-> $stable(rca_o))
        else $error("address changed without a command");
    chk_select_match: assert property (sel_v && adr == rca_o
        && $past(state_o) inside {CAR_STBY, CAR_TRAN}
        |-> state_o == CAR_TRAN)
        else $error("matching select not acted on");
    chk_foreign_cmd: assert property (nat_v && adr != rca_o
        && cmd_o.index == CMD_CARD_SELECT && adr != RCA_ALL_STBY
        |-> !cmd_for_me_o)
        else $error("foreign select acted on");
    chk_all_standby: assert property (sel_v && adr == RCA_ALL_STBY
        && $past(state_o) inside {CAR_STBY, CAR_TRAN}
        |-> state_o == CAR_STBY)
        else $error("reserved address did not give stand-by");
    chk_sw_reset: assert property (nat_v && $past(state_o) != CAR_INACTIVE
        && cmd_o.index == CMD_SW_RESET
        |-> state_o == CAR_IDLE && rca_o == RCA_RESET)
        else $error("software reset not applied");
    chk_inactive_keep: assert property (state_o == CAR_INACTIVE
        |=> state_o == CAR_INACTIVE)
        else $error("inactive card left inactive state");
    chk_spi_refuse: assert property (rd_i && spi_mode_i && !blk
        |=> rd_refused_o && !rd_done_o && rd_data_o == 8'h00)
        else $error("serial mode read not refused");
    chk_block_read: assert property (rd_i && blk
        |=> rd_done_o && !rd_refused_o)
        else $error("block read not answered");
    chk_short_status: assert property (spi_mode_i [*2] |->
        status_o[31:3] == 29'h0 && !status_o[1])
        else $error("serial status not in short format");
endmodule

bind car_regs car_regs_properties i_chk (.ref_clk_i, .rst_i, .spi_mode_i,
    .rd_i, .rd_req_i, .rd_done_o, .rd_refused_o, .rd_data_o, .cmd_valid_o,
    .cmd_o, .cmd_for_me_o, .rca_o, .state_o, .status_o);

// >>> verification/testbench.sv
// Testbench: host model on the command line plus direct register reads.
// Assumes the block, the host model and the bound checker are compiled.
`timescale 1ns/1ps
module testbench
    import car_pkg::*;
;
    localparam int LIMIT = 20000;
    logic        ref_clk_i    = 1'b0;
    logic        rst_i        = 1'b1;
    logic        spi_mode_i   = 1'b0;
    logic        id_wr_i      = 1'b0;
    logic        id_wr_blk_i  = 1'b0;
    logic [3:0]  id_wr_idx_i  = 4'h0;
    logic [7:0]  id_wr_data_i = 8'h00;
    logic        rd_i         = 1'b0;
    car_rd_req_t rd_req_i     = '0;
    logic        go           = 1'b0;
    logic        bad          = 1'b0;
    logic [39:0] frm          = '0;
    logic        me_seen      = 1'b0;
    logic        rd_done_o, rd_refused_o, cmd_valid_o, cmd_for_me_o;
    logic        card_clk, cmd, busy;
    logic [7:0]  rd_data_o;
    logic [15:0] rca_o;
    logic [31:0] status_o;
    car_cmd_t    cmd_o;
    car_state_t  state_o;
    int          err_count    = 0;
    int          compares     = 0;
    int          cycles       = 0;

    car_regs i_dut (.ref_clk_i, .rst_i, .card_clk_i(card_clk), .cmd_i(cmd),
        .spi_mode_i, .id_wr_i, .id_wr_blk_i, .id_wr_idx_i, .id_wr_data_i,
        .rd_i, .rd_req_i, .rd_done_o, .rd_refused_o, .rd_data_o,
        .cmd_valid_o, .cmd_o, .cmd_for_me_o, .rca_o, .state_o, .status_o);
    car_host_model i_host (.go_i(go), .frm_i(frm), .bad_i(bad),
        .card_clk_o(card_clk), .cmd_o(cmd), .busy_o(busy));

    initial
    begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i)
    begin
        cycles <= cycles + 1;
        if (go)
            me_seen <= 1'b0;
        else if (cmd_valid_o === 1'b1 && cmd_for_me_o === 1'b1)
            me_seen <= 1'b1;
        if (cycles == LIMIT)
        begin
            err_count++;
            wrap_up();
        end
    end

    // ====================================
    // Shared tasks
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic do_reset();
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        tick(16);
        rst_i <= 1'b0;
        tick(1);
        #1;
    endtask

    task automatic send(input logic [5:0] idx, input logic [31:0] arg,
                        input logic b);
        @(posedge ref_clk_i);
        frm     <= {2'b01, idx, arg};
        bad     <= b;
        go      <= 1'b1;
        @(posedge ref_clk_i);
        go <= 1'b0;
        for (int n = 0; n < 600 && busy; n++)
            @(posedge ref_clk_i);
        tick(8);
        #1;
    endtask

    task automatic rd(input car_reg_sel_t s, input logic [3:0] i,
                      input logic ok, input logic [7:0] d);
        @(posedge ref_clk_i);
        rd_i     <= 1'b1;
        rd_req_i <= '{s, i};
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(32'({rd_done_o, rd_refused_o, rd_data_o}), 32'({ok, !ok, d}));
    endtask

    function automatic logic [7:0] pat(input int k);
        return 8'(k * 7 + 8'h31);
    endfunction

    task automatic ident(input logic [15:0] a);
        send(CMD_SEND_OPCOND, 32'h0, 1'b0);
        chk(state_o, CAR_READY);
        send(CMD_ALL_SEND_ID, 32'h0, 1'b0);
        chk(state_o, CAR_IDENT);
        send(CMD_SET_ADDR, {a, 16'h0000}, 1'b0);
        chk(rca_o, a);
        chk(state_o, CAR_STBY);
    endtask

    // ====================================
    // Scenarios
    task automatic t_ident();
        for (int k = 0; k < 32; k++)
        begin
            @(posedge ref_clk_i);
            id_wr_i      <= 1'b1;
            id_wr_blk_i  <= k[4];
            id_wr_idx_i  <= k[3:0];
            id_wr_data_i <= pat(k);
        end
        @(posedge ref_clk_i);
        id_wr_i <= 1'b0;
        #1;
        chk(rca_o, RCA_RESET);
        chk(status_o, 32'h100);
        ident(16'h1234);
        rd(CAR_REG_RCA, 4'h0, 1'b1, 8'h34);
        rd(CAR_REG_RCA, 4'h1, 1'b1, 8'h12);
        $display("test ident done");
    endtask

    task automatic t_select();
        send(CMD_CARD_SELECT, 32'h55550000, 1'b0);
        chk(me_seen, 1'b0);
        send(CMD_CARD_SELECT, 32'h12340000, 1'b0);
        chk(me_seen, 1'b1);
        chk(state_o, CAR_TRAN);
        chk(cmd_o.arg, 32'h12340000);
        send(CMD_SEND_STATUS, 32'h55550000, 1'b0);
        chk(me_seen, 1'b0);
        send(CMD_CARD_SELECT, 32'h0, 1'b1);
        chk(state_o, CAR_TRAN);
        send(CMD_CARD_SELECT, 32'h0, 1'b0);
        chk(state_o, CAR_STBY);
        $display("test select done");
    endtask

    task automatic t_sw_reset();
        send(CMD_SW_RESET, 32'h0, 1'b0);
        chk(state_o, CAR_IDLE);
        chk(rca_o, RCA_RESET);
        ident(16'hbeef);
        send(CMD_GO_INACTIVE, 32'hbeef0000, 1'b0);
        chk(state_o, CAR_INACTIVE);
        send(CMD_SW_RESET, 32'h0, 1'b0);
        chk(state_o, CAR_INACTIVE);
        chk(rca_o, 16'hbeef);
        do_reset();
        chk(rca_o, RCA_RESET);
        chk(state_o, CAR_IDLE);
        $display("test software reset done");
    endtask

    task automatic t_spi();
        @(posedge ref_clk_i);
        spi_mode_i <= 1'b1;
        tick(2);
        #1;
        chk(status_o, 32'h1);
        for (int k = 0; k < 32; k++)
            rd(k[4] ? CAR_REG_CSD : CAR_REG_CID, k[3:0], 1'b1, pat(k));
        rd(CAR_REG_RCA, 4'h0, 1'b0, 8'h00);
        rd(CAR_REG_DSR, 4'h0, 1'b0, 8'h00);
        rd(CAR_REG_OCR, 4'h0, 1'b0, 8'h00);
        send(CMD_SET_ADDR, 32'h43210000, 1'b0);
        chk(status_o, 32'h5);
        chk(rca_o, RCA_RESET);
        $display("test serial mode done");
    endtask

    initial
    begin
        do_reset();
        t_ident();
        t_select();
        t_sw_reset();
        t_spi();
        wrap_up();
    end
endmodule
